// >>> rcsp_top.sv
`timescale 1ns/100ps
`include "rcsp_regs.svh"
// What this block does
// - Override set: address bits 5..3 come from page number, low bits from latch or address pins.
// - Override clear: whole address comes from the address latch; page number ignored.
// - Paging register decodes at offset 0 of every page; resets to 80h.
// - Host writes command code to bits 5..0; reads return running command.
// - Command bit 7 reads 1 while host-port detection pending, 0 after.
// - Data port writes push to the 64-byte queue, reads pop from it.
// - Status bits 6..4 report the link state code.
// - Payload state sends queue bytes or the appended check bits.
// - Receive guard waits the programmed delay before listening.
// - Listening waits for receive input, then enters receiving.
// - Status bit 3 set while any enabled interrupt source 0..5 requests; sources 6 and 7 are ignored.
// - Status bit 2 set while any error flag is set.
// - Status bit 1 is one when 64 minus fill count <= threshold.
// - Status bit 0 is one when fill count <= threshold.
// - Fill count rises per queue write and falls per queue read.
module rcsp_top #(
   parameter int QUEUE_DEPTH = `RCSP_QUEUE_DEPTH,
   parameter int QUEUE_AW    = 6
) (
   input  wire logic                  clk_in,
   input  wire logic                  sys_rst_in,
   // Host parallel port, already resolved to strobes
   input  wire logic                  addr_latch_in,
   input  wire logic [5:0]            addr_bus_in,
   input  wire logic                  use_addr_pins_in,
   input  wire logic [2:0]            addr_pins_in,
   input  wire logic                  wr_strobe_in,
   input  wire logic                  rd_strobe_in,
   input  wire logic [7:0]            wr_data_in,
   output logic      [7:0]            rd_data_out,
   output logic      [5:0]            reg_addr_out,
   // Surrounding device
   input  wire logic                  host_port_detect_pending_in,
   input  wire logic [7:0]            interrupt_mask_register_in,
   input  wire logic [7:0]            interrupt_request_in,
   input  wire logic [7:0]            error_flag_register_in,
   input  wire logic [5:0]            alert_threshold_in,
   input  wire logic [7:0]            receive_guard_delay_in,
   input  wire logic                  crc_enable_in,
   input  wire logic                  command_done_in,
   input  wire logic                  rx_signal_in,
   input  wire logic                  rx_done_in,
   input  wire logic                  rx_byte_valid_in,
   input  wire logic [7:0]            rx_byte_in,
   output logic      [5:0]            command_code_out,
   output logic                       command_start_out,
   output logic      [7:0]            tx_byte_out,
   output logic                       tx_byte_valid_out,
   output logic                       crc_phase_out,
   output logic      [2:0]            link_state_out,
   output logic      [QUEUE_AW:0]     queue_fill_count_out
);
   // ---------------------------------------------------------------
   // Address forming
   // ---------------------------------------------------------------
   logic [5:0] latch_r;
   logic [7:0] page_r;
   logic [5:0] addr;
   logic [2:0] low_bits;
   logic [5:0] cmd_r;
   logic [7:0] status;
   logic [7:0] queue_rd;
   logic       q_push;
   logic       q_pop;
   logic       fsm_pop;
   logic       hit_page;
   logic       hit_cmd;
   logic       hit_data;
   logic       hit_status;
   logic       near_full;
   logic       near_empty;
   logic [QUEUE_AW:0] fill;
   rcsp_pkg::rcsp_link_state_t lstate;

   initial
   begin
      if (QUEUE_DEPTH != 64 || QUEUE_AW != 6)
         $error("rcsp_top: queue is fixed at 64 bytes");
   end

   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
         latch_r <= 6'h00;
      else if (addr_latch_in)
         latch_r <= addr_bus_in;
   end

   assign low_bits = use_addr_pins_in ? addr_pins_in : latch_r[2:0];

   always_comb
   begin
      if (page_r[`RCSP_PAGE_OVR_BIT])
         addr = {page_r[2:0], low_bits};
      else
         addr = latch_r;
   end

   assign reg_addr_out = addr;

   // ---------------------------------------------------------------
   // Decode
   // ---------------------------------------------------------------
   // Paging register ignores the page bits so it answers in every page
   assign hit_page   = addr[2:0] == `RCSP_OFF_PAGE_SELECT;
   assign hit_cmd    = addr == {3'h0, `RCSP_OFF_COMMAND};
   assign hit_data   = addr == {3'h0, `RCSP_OFF_QUEUE_DATA};
   assign hit_status = addr == {3'h0, `RCSP_OFF_PRIMARY_STATE};

   // ---------------------------------------------------------------
   // Paging register
   // ---------------------------------------------------------------
   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
         page_r <= `RCSP_PAGE_RESET;
      else if (wr_strobe_in && hit_page)
         page_r <= {wr_data_in[7], 4'h0, wr_data_in[2:0]};
   end

   // ---------------------------------------------------------------
   // Command register
   // ---------------------------------------------------------------
   // Code clears to idle when the command reports completion
   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
         cmd_r <= `RCSP_CMD_RESET;
      else if (wr_strobe_in && hit_cmd)
         cmd_r <= wr_data_in[5:0];
      else if (command_done_in)
         cmd_r <= `RCSP_CMD_RESET;
   end

   assign command_code_out  = cmd_r;
   assign command_start_out = wr_strobe_in && hit_cmd && (wr_data_in[5:0] != 6'h00);

   // ---------------------------------------------------------------
   // Queue and link
   // ---------------------------------------------------------------
   // Host writes win over received bytes; host has priority on the port
   assign q_push = (wr_strobe_in && hit_data) || rx_byte_valid_in;
   assign q_pop  = (rd_strobe_in && hit_data) || fsm_pop;

   rcsp_queue #(
      .DEPTH (QUEUE_DEPTH),
      .AW    (QUEUE_AW)
   ) i_rcsp_queue (
      .clk_in         (clk_in),
      .sys_rst_in     (sys_rst_in),
      .push_in        (q_push),
      .push_data_in   ((wr_strobe_in && hit_data) ? wr_data_in : rx_byte_in),
      .pop_in         (q_pop),
      .pop_data_out   (queue_rd),
      .fill_count_out (fill)
   );

   rcsp_link_fsm i_rcsp_link_fsm (
      .clk_in                 (clk_in),
      .sys_rst_in             (sys_rst_in),
      .start_in               (command_start_out),
      .abort_in               (wr_strobe_in && hit_cmd && wr_data_in[5:0] == 6'h00),
      .queue_empty_in         (fill == '0),
      .crc_enable_in          (crc_enable_in),
      .receive_guard_delay_in (receive_guard_delay_in),
      .rx_signal_in           (rx_signal_in),
      .rx_done_in             (rx_done_in),
      .pop_out                (fsm_pop),
      .crc_phase_out          (crc_phase_out),
      .link_state_out         (lstate)
   );

   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         tx_byte_out       <= 8'h00;
         tx_byte_valid_out <= 1'b0;
      end
      else
      begin
         tx_byte_valid_out <= fsm_pop;
         if (fsm_pop)
            tx_byte_out <= queue_rd;
      end
   end

   assign link_state_out       = lstate;
   assign queue_fill_count_out = fill;

   // ---------------------------------------------------------------
   // Status
   // ---------------------------------------------------------------
   assign near_full  = ((QUEUE_AW+1)'(QUEUE_DEPTH) - fill)
                       <= {1'b0, alert_threshold_in};
   assign near_empty = fill <= {1'b0, alert_threshold_in};

   always_comb
   begin
      status                    = 8'h00;
      status[6:`RCSP_STATE_LSB] = lstate;
      status[`RCSP_IRQ_BIT]     = |(interrupt_mask_register_in[5:0]
                                    & interrupt_request_in[5:0]);
      status[`RCSP_ERR_BIT]     = |error_flag_register_in;
      status[`RCSP_FULL_BIT]    = near_full;
      status[`RCSP_EMPTY_BIT]   = near_empty;
   end

   // ---------------------------------------------------------------
   // Read data
   // ---------------------------------------------------------------
   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
         rd_data_out <= 8'h00;
      else if (rd_strobe_in)
      begin
         if (hit_page)
            rd_data_out <= page_r;
         else if (hit_cmd)
            rd_data_out <= {host_port_detect_pending_in, 1'b0, cmd_r};
         else if (hit_data)
            rd_data_out <= queue_rd;
         else if (hit_status)
            rd_data_out <= status;
         else
            rd_data_out <= 8'h00;
      end
   end

   chk_page_addr: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      page_r[7] |-> reg_addr_out[5:3] == page_r[2:0])
      else $error("page number not used");
   chk_latch_addr: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      !page_r[7] |-> reg_addr_out == latch_r)
      else $error("latch address not used");
   chk_page_reset: assert property (@(posedge clk_in)
      sys_rst_in |=> page_r == 8'h80)
      else $error("paging reset value wrong");
   chk_cmd_read: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      rd_strobe_in && hit_cmd |=> rd_data_out[5:0] == $past(cmd_r))
      else $error("command readback wrong");
   chk_detect_bit: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      rd_strobe_in && hit_cmd |=> rd_data_out[7] == $past(host_port_detect_pending_in))
      else $error("detect bit wrong");
   chk_state_field: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      rd_strobe_in && hit_status |=> rd_data_out[6:4] == $past(link_state_out))
      else $error("state field wrong");
   chk_irq_bit: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (interrupt_mask_register_in[5:0] & interrupt_request_in[5:0]) == 6'h00
      |-> !status[3])
      else $error("irq summary set with nothing enabled");
   chk_err_bit: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      status[2] == (error_flag_register_in != 8'h00))
      else $error("error summary wrong");
   chk_full_alert: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (fill == 7'h3C && alert_threshold_in == 6'h04) |-> status[1])
      else $error("nearly full not raised");
   chk_empty_alert: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      (fill == 7'h05 && alert_threshold_in == 6'h04) |-> !status[0])
      else $error("nearly empty wrongly raised");
   cov_queue_full: cover property (@(posedge clk_in) fill == 7'h40);
   cov_page_off: cover property (@(posedge clk_in) wr_strobe_in && hit_page && !wr_data_in[7]);
   cov_status_rd: cover property (@(posedge clk_in) rd_strobe_in && hit_status);
endmodule

// >>> rcsp_regs.svh
`ifndef RCSP_REGS_SVH
`define RCSP_REGS_SVH
// Register offsets within a page
`define RCSP_OFF_PAGE_SELECT   3'h0
`define RCSP_OFF_COMMAND       3'h1
`define RCSP_OFF_QUEUE_DATA    3'h2
`define RCSP_OFF_PRIMARY_STATE 3'h3
// Field positions
`define RCSP_PAGE_OVR_BIT      7
`define RCSP_DETECT_BIT        7
`define RCSP_STATE_LSB         4
`define RCSP_IRQ_BIT           3
`define RCSP_ERR_BIT           2
`define RCSP_FULL_BIT          1
`define RCSP_EMPTY_BIT         0
// Reset values and queue depth
`define RCSP_PAGE_RESET        8'h80
`define RCSP_CMD_RESET         6'h00
`define RCSP_QUEUE_DEPTH       64
`endif

// >>> rcsp_pkg.sv
package rcsp_pkg;
   typedef enum logic [2:0]
   {
      RCSP_IDLE        = 3'b000,
      RCSP_FRAME_START = 3'b001,
      RCSP_PAYLOAD     = 3'b010,
      RCSP_FRAME_END   = 3'b011,
      RCSP_TURNAROUND  = 3'b100,
      RCSP_RX_GUARD    = 3'b101,
      RCSP_LISTENING   = 3'b110,
      RCSP_RECEIVING   = 3'b111
   } rcsp_link_state_t;
endpackage

// >>> rcsp_queue.sv
`timescale 1ns/100ps
// Byte queue: push and pop in one cycle allowed; full refuses push unless popped in the same cycle, empty pops nothing
module rcsp_queue #(
   parameter int DEPTH = 64,
   parameter int AW    = 6
) (
   input  wire logic         clk_in,
   input  wire logic         sys_rst_in,
   input  wire logic         push_in,
   input  wire logic [7:0]   push_data_in,
   input  wire logic         pop_in,
   output logic      [7:0]   pop_data_out,
   output logic      [AW:0]  fill_count_out
);
   logic [7:0]  mem [DEPTH];
   logic [AW-1:0] wr_ptr_r;
   logic [AW-1:0] rd_ptr_r;
   logic [AW:0]   count_r;
   logic          do_push;
   logic          do_pop;

   initial
   begin
      if (DEPTH != (1 << AW))
         $error("rcsp_queue: DEPTH must equal 2**AW");
   end

   assign do_pop  = pop_in && (count_r != '0);
   assign do_push = push_in && ((count_r != (AW+1)'(DEPTH)) || do_pop);

   always_ff @(posedge clk_in)
   begin
      if (do_push)
         mem[wr_ptr_r] <= push_data_in;
   end

   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
      end
      else
      begin
         if (do_push)
            wr_ptr_r <= wr_ptr_r + 1'b1;
         if (do_pop)
            rd_ptr_r <= rd_ptr_r + 1'b1;
         // One up per write, one down per read
         if (do_push && !do_pop)
            count_r <= count_r + 1'b1;
         else if (do_pop && !do_push)
            count_r <= count_r - 1'b1;
      end
   end

   assign pop_data_out   = mem[rd_ptr_r];
   assign fill_count_out = count_r;

   chk_count_push: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      do_push && !do_pop |=> count_r == $past(count_r) + 1'b1)
      else $error("fill count did not rise on push");
   chk_count_pop: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      do_pop && !do_push |=> count_r == $past(count_r) - 1'b1)
      else $error("fill count did not fall on pop");
endmodule

// >>> rcsp_link_fsm.sv
`timescale 1ns/100ps
// Sequencer of transmit and receive phases, reported as a 3-bit state
module rcsp_link_fsm (
   input  wire logic                      clk_in,
   input  wire logic                      sys_rst_in,
   input  wire logic                      start_in,
   input  wire logic                      abort_in,
   input  wire logic                      queue_empty_in,
   input  wire logic                      crc_enable_in,
   input  wire logic [7:0]                receive_guard_delay_in,
   input  wire logic                      rx_signal_in,
   input  wire logic                      rx_done_in,
   output logic                           pop_out,
   output logic                           crc_phase_out,
   output rcsp_pkg::rcsp_link_state_t     link_state_out
);
   rcsp_pkg::rcsp_link_state_t state_r;
   logic [7:0] guard_cnt_r;
   logic       turn_two_r;
   logic       crc_done_r;

   // Payload takes bytes from the queue, then the check bits
   assign pop_out       = (state_r == rcsp_pkg::RCSP_PAYLOAD) && !queue_empty_in;
   assign crc_phase_out = (state_r == rcsp_pkg::RCSP_PAYLOAD) && queue_empty_in
                          && crc_enable_in && !crc_done_r;

   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         state_r     <= rcsp_pkg::RCSP_IDLE;
         guard_cnt_r <= 8'h00;
         turn_two_r  <= 1'b0;
         crc_done_r  <= 1'b0;
      end
      else if (abort_in)
      begin
         state_r <= rcsp_pkg::RCSP_IDLE;
      end
      else
      begin
         case (state_r)
            rcsp_pkg::RCSP_IDLE:
               if (start_in)
               begin
                  state_r    <= rcsp_pkg::RCSP_FRAME_START;
                  crc_done_r <= 1'b0;
               end
            rcsp_pkg::RCSP_FRAME_START:
               state_r <= rcsp_pkg::RCSP_PAYLOAD;
            rcsp_pkg::RCSP_PAYLOAD:
               if (crc_phase_out)
                  crc_done_r <= 1'b1;
               else if (queue_empty_in)
                  state_r <= rcsp_pkg::RCSP_FRAME_END;
            rcsp_pkg::RCSP_FRAME_END:
            begin
               state_r    <= rcsp_pkg::RCSP_TURNAROUND;
               turn_two_r <= 1'b0;
            end
            // Both turnaround steps share one code
            rcsp_pkg::RCSP_TURNAROUND:
               if (turn_two_r)
               begin
                  state_r     <= rcsp_pkg::RCSP_RX_GUARD;
                  guard_cnt_r <= receive_guard_delay_in;
               end
               else
                  turn_two_r <= 1'b1;
            rcsp_pkg::RCSP_RX_GUARD:
               if (guard_cnt_r == 8'h00)
                  state_r <= rcsp_pkg::RCSP_LISTENING;
               else
                  guard_cnt_r <= guard_cnt_r - 8'h01;
            rcsp_pkg::RCSP_LISTENING:
               if (rx_signal_in)
                  state_r <= rcsp_pkg::RCSP_RECEIVING;
            rcsp_pkg::RCSP_RECEIVING:
               if (rx_done_in)
                  state_r <= rcsp_pkg::RCSP_IDLE;
            default:
               state_r <= rcsp_pkg::RCSP_IDLE;
         endcase
      end
   end

   assign link_state_out = state_r;

   chk_guard_wait: assert property (@(posedge clk_in) disable iff (sys_rst_in || abort_in)
      state_r == rcsp_pkg::RCSP_RX_GUARD && guard_cnt_r != 8'h00
      |=> state_r == rcsp_pkg::RCSP_RX_GUARD)
      else $error("left receive guard early");
   chk_listen_enter: assert property (@(posedge clk_in) disable iff (sys_rst_in || abort_in)
      state_r == rcsp_pkg::RCSP_LISTENING && rx_signal_in
      |=> state_r == rcsp_pkg::RCSP_RECEIVING)
      else $error("did not start receiving");
   chk_listen_hold: assert property (@(posedge clk_in) disable iff (sys_rst_in || abort_in)
      state_r == rcsp_pkg::RCSP_LISTENING && !rx_signal_in
      |=> state_r == rcsp_pkg::RCSP_LISTENING)
      else $error("left listening without signal");
   chk_payload_pop: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      pop_out |-> state_r == rcsp_pkg::RCSP_PAYLOAD)
      else $error("queue read outside payload");
   cov_full_frame: cover property (@(posedge clk_in)
      state_r == rcsp_pkg::RCSP_RECEIVING && rx_done_in);
   cov_crc_sent: cover property (@(posedge clk_in) crc_phase_out);
endmodule

// >>> rcsp_card_model.sv
`timescale 1ns/100ps
// -----------------------------------------------------------
// Far-end model: replies to a listening receiver, two bytes
// -----------------------------------------------------------
module rcsp_card_model #(
   parameter int REPLY_WAIT = 10
) (
   input  wire logic       clk_in,
   input  wire logic       sys_rst_in,
   input  wire logic [2:0] link_state_in,
   output logic            rx_signal_out,
   output logic            rx_done_out,
   output logic            rx_byte_valid_out,
   output logic [7:0]      rx_byte_out,
   output logic            command_done_out
);
   int cnt;
   int sent;

   always @(posedge clk_in)
   begin
      rx_done_out       <= 1'b0;
      rx_byte_valid_out <= 1'b0;
      command_done_out  <= 1'b0;
      // Idle data line toggles so stale bytes never look valid
      rx_byte_out       <= ~rx_byte_out;
      if (sys_rst_in || link_state_in < 3'h6)
      begin
         cnt           <= 0;
         sent          <= 0;
         rx_signal_out <= 1'b0;
         if (sys_rst_in)
            rx_byte_out <= 8'h00;
      end
      else if (link_state_in == 3'h6)
      begin
         cnt <= cnt + 1;
         if (cnt == REPLY_WAIT)
            rx_signal_out <= 1'b1;
      end
      else if (sent < 2)
      begin
         rx_byte_valid_out <= 1'b1;
         rx_byte_out       <= (sent == 0) ? 8'h5A : 8'hA5;
         sent              <= sent + 1;
      end
      else if (sent == 2)
      begin
         rx_done_out      <= 1'b1;
         command_done_out <= 1'b1;
         sent             <= 3;
      end
   end
endmodule

// >>> test_reader_command_status_page.sv
`timescale 1ns/100ps
module test_reader_command_status_page;
   logic       clk_in = 1'b0;
   logic       sys_rst_in = 1'b1;
   logic       addr_latch_in = 1'b0;
   logic [5:0] addr_bus_in = 6'h00;
   logic       use_addr_pins_in = 1'b0;
   logic [2:0] addr_pins_in = 3'h0;
   logic       wr_strobe_in = 1'b0;
   logic       rd_strobe_in = 1'b0;
   logic [7:0] wr_data_in = 8'h00;
   logic       host_port_detect_pending_in = 1'b1;
   logic [7:0] interrupt_mask_register_in = 8'h00;
   logic [7:0] interrupt_request_in = 8'h00;
   logic [7:0] error_flag_register_in = 8'h00;
   logic [5:0] alert_threshold_in = 6'h00;
   logic [7:0] receive_guard_delay_in = 8'h00;
   logic       crc_enable_in = 1'b0;
   logic       command_done_in, rx_signal_in, rx_done_in, rx_byte_valid_in;
   logic [7:0] rx_byte_in, rd_data_out, tx_byte_out, rdv;
   logic [5:0] reg_addr_out, command_code_out;
   logic       command_start_out, tx_byte_valid_out, crc_phase_out;
   logic [2:0] link_state_out;
   logic [6:0] queue_fill_count_out;
   logic [2:0] seq[$];
   int         lens[$];
   logic [7:0] txq[$];
   int         crcn = 0;
   int         starts = 0;
   logic       mon_on = 1'b0;
   int         mismatches = 0;
   int         n_tests = 0;
   logic [2:0] exp_seq[9] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7, 3'h0};

   rcsp_top i_rcsp_top (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .addr_latch_in(addr_latch_in),
      .addr_bus_in(addr_bus_in), .use_addr_pins_in(use_addr_pins_in), .addr_pins_in(addr_pins_in),
      .wr_strobe_in(wr_strobe_in), .rd_strobe_in(rd_strobe_in), .wr_data_in(wr_data_in),
      .rd_data_out(rd_data_out), .reg_addr_out(reg_addr_out),
      .host_port_detect_pending_in(host_port_detect_pending_in),
      .interrupt_mask_register_in(interrupt_mask_register_in),
      .interrupt_request_in(interrupt_request_in), .error_flag_register_in(error_flag_register_in),
      .alert_threshold_in(alert_threshold_in), .receive_guard_delay_in(receive_guard_delay_in),
      .crc_enable_in(crc_enable_in), .command_done_in(command_done_in),
      .rx_signal_in(rx_signal_in), .rx_done_in(rx_done_in), .rx_byte_valid_in(rx_byte_valid_in),
      .rx_byte_in(rx_byte_in), .command_code_out(command_code_out),
      .command_start_out(command_start_out), .tx_byte_out(tx_byte_out),
      .tx_byte_valid_out(tx_byte_valid_out), .crc_phase_out(crc_phase_out),
      .link_state_out(link_state_out), .queue_fill_count_out(queue_fill_count_out));

   rcsp_card_model i_rcsp_card_model (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
      .link_state_in(link_state_out), .rx_signal_out(rx_signal_in), .rx_done_out(rx_done_in),
      .rx_byte_valid_out(rx_byte_valid_in), .rx_byte_out(rx_byte_in),
      .command_done_out(command_done_in));

   initial
   begin
      forever #12.5 clk_in = ~clk_in;
   end

   // -----------------------------------------------------------
   // Host port tasks
   // -----------------------------------------------------------
   task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp)
      begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic latch(input logic [5:0] a);
      @(posedge clk_in);
      addr_latch_in <= 1'b1;
      addr_bus_in   <= a;
      @(posedge clk_in);
      addr_latch_in <= 1'b0;
   endtask

   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      latch(a);
      wr_strobe_in <= 1'b1;
      wr_data_in   <= d;
      @(posedge clk_in);
      wr_strobe_in <= 1'b0;
   endtask

   task automatic rdc(input logic [5:0] a, input logic [7:0] exp, input string name);
      latch(a);
      rd_strobe_in <= 1'b1;
      @(posedge clk_in);
      rd_strobe_in <= 1'b0;
      #1 check(name, exp, rd_data_out);
   endtask

   function automatic logic [7:0] stat(input int fill, input logic [2:0] st);
      stat = {1'b0, st, |(interrupt_mask_register_in[5:0] & interrupt_request_in[5:0]),
              |error_flag_register_in, (64 - fill) <= alert_threshold_in,
              fill <= alert_threshold_in};
   endfunction

   task automatic results();
      if (mismatches == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // Link monitor: run-length record of state codes and sent bytes
   always @(posedge clk_in)
   begin
      if (mon_on)
      begin
         if (seq.size() != 0 && link_state_out === seq[$])
            lens[$]++;
         else
         begin
            seq.push_back(link_state_out);
            lens.push_back(1);
         end
         if (tx_byte_valid_out === 1'b1)
            txq.push_back(tx_byte_out);
         if (crc_phase_out === 1'b1)
            crcn++;
         if (command_start_out === 1'b1)
            starts++;
      end
   end

   initial
   begin
      #300000;
      mismatches++;
      results();
   end

   // -----------------------------------------------------------
   // Tests
   // -----------------------------------------------------------
   initial
   begin
      repeat (3) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      rdc(6'h00, 8'h80, "page");
      rdc(6'h03, stat(0, 3'h0), "status");
      rdc(6'h01, 8'h80, "command");
      host_port_detect_pending_in <= 1'b0;
      rdc(6'h01, 8'h00, "command");
      wr(6'h00, 8'h83);
      latch(6'h02);
      #1 check("addr", 8'h1A, {2'b00, reg_addr_out});
      @(posedge clk_in);
      use_addr_pins_in <= 1'b1;
      addr_pins_in     <= 3'h5;
      #1 check("addr", 8'h1D, {2'b00, reg_addr_out});
      @(posedge clk_in);
      use_addr_pins_in <= 1'b0;
      rdc(6'h00, 8'h83, "page");
      wr(6'h00, 8'h07);
      latch(6'h2A);
      #1 check("addr", 8'h2A, {2'b00, reg_addr_out});
      rdc(6'h08, 8'h07, "page");
      wr(6'h38, 8'h80);
      rdc(6'h00, 8'h80, "page");
      // Fill past full: the extra byte must be refused
      alert_threshold_in <= 6'h04;
      for (int i = 0; i < 65; i++)
         wr(6'h02, 8'(i + 16));
      #1 check("fill", 8'h40, {1'b0, queue_fill_count_out});
      for (int i = 0; i < 64; i++)
      begin
         rdc(6'h03, stat(64 - i, 3'h0), "status");
         rdc(6'h02, 8'(i + 16), "queue");
      end
      #1 check("fill", 8'h00, {1'b0, queue_fill_count_out});
      for (int b = 0; b < 8; b++)
      begin
         @(posedge clk_in);
         interrupt_mask_register_in <= 8'h01 << b;
         interrupt_request_in       <= (b % 2) ? ~(8'h01 << b) : 8'h01 << b;
         error_flag_register_in     <= 8'h01 << b;
         #1 rdc(6'h03, stat(0, 3'h0), "status");
      end
      @(posedge clk_in);
      interrupt_mask_register_in <= 8'h00;
      error_flag_register_in     <= 8'h00;
      crc_enable_in              <= 1'b1;
      receive_guard_delay_in     <= 8'h05;
      for (int i = 0; i < 3; i++)
         wr(6'h02, 8'hC0 + 8'(i));
      mon_on = 1'b1;
      wr(6'h01, 8'h0C);
      #1 check("code", 8'h0C, {2'b00, command_code_out});
      rdc(6'h01, 8'h0C, "command");
      for (int k = 0; k < 300 && link_state_out !== 3'h6; k++)
         @(posedge clk_in);
      rdc(6'h03, stat(0, 3'h6), "status");
      for (int k = 0; k < 300 && link_state_out !== 3'h0; k++)
         @(posedge clk_in);
      @(posedge clk_in);
      mon_on = 1'b0;
      for (int k = 0; k < 9; k++)
         check("state", 8'(exp_seq[k]), 8'(seq[k]));
      // Three bytes, one check cycle, one cycle to see the queue empty
      check("payload_len", 8'h05, 8'(lens[2]));
      check("turn_len", 8'h02, 8'(lens[4]));
      check("guard_len", 8'h06, 8'(lens[5]));
      check("crc", 8'h01, 8'(crcn));
      check("starts", 8'h01, 8'(starts));
      for (int k = 0; k < 3; k++)
         check("tx", 8'hC0 + 8'(k), txq[k]);
      rdc(6'h02, 8'h5A, "queue");
      rdc(6'h02, 8'hA5, "queue");
      rdc(6'h01, 8'h00, "command");
      // Code zero written mid-payload must drop the link back to idle
      wr(6'h01, 8'h0C);
      wr(6'h01, 8'h00);
      #1 check("abort", 8'h00, {5'h00, link_state_out});
      results();
   end
endmodule
